// File: rtl/rgi_pkg.sv
// Constants, encodings and carrier types for the RGMII tri-speed physical interface
package rgi_pkg;

   // Link speed encoding on the speed select input
   typedef enum logic [1:0] {
      RGI_SPD_10M  = 2'h0,
      RGI_SPD_100M = 2'h1,
      RGI_SPD_1G   = 2'h2
   } rgi_speed_t;

   // Reference clock and strobe divisors
   localparam int RGI_REF_CLK_MHZ = 125;
   localparam int RGI_CLK_PERIOD_NS = 1000 / RGI_REF_CLK_MHZ;
   localparam int RGI_DIV_1G = 1;
   localparam int RGI_DIV_100M = 10;
   localparam int RGI_DIV_10M = 100;
   localparam int RGI_CNT_W = 7;

   // Forwarded clock skew at gigabit, met by the quadrature reference
   localparam int RGI_TXC_SKEW_NS = 2;
   localparam int RGI_TXC_SKEW_QUARTERS = (RGI_TXC_SKEW_NS * 4) / RGI_CLK_PERIOD_NS;

   // Reset values
   localparam logic [3:0] RGI_NIBBLE_RST = 4'h0;
   localparam logic [7:0] RGI_BYTE_RST = 8'h00;
   localparam logic [RGI_CNT_W-1:0] RGI_CNT_RST = 7'h00;

   // Two-edge output register contents: value for the rising and for the falling half
   typedef struct packed {
      logic [3:0] d_rise;
      logic [3:0] d_fall;
      logic ctl_rise;
      logic ctl_fall;
      logic clk_rise;
      logic clk_fall;
   } rgi_ddr_t;

   localparam rgi_ddr_t RGI_DDR_RST = '{4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0};

   // One byte with its frame flags
   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic error;
   } rgi_word_t;

   localparam rgi_word_t RGI_WORD_RST = '{8'h00, 1'b0, 1'b0};

endpackage : rgi_pkg

// File: rtl/rgi_phy_if.sv
// RGMII tri-speed transmit and receive adapter between a MAC datapath and an external PHY
`timescale 1ns/100ps

// Summary of operation
// - All transmit logic and user transmit handshake run on the 125 MHz reference.
// - Transmit strobe: every cycle at 1G, one in ten at 100M, one in hundred at 10M.
// - The transmit strobe is made here and handed to the MAC as its qualifier.
// - Transmit data and control leave through two-edge output registers at the pads.
// - Forwarded clock rises from the same two-edge register as data; its falling half is re-held on the falling reference edge.
// - At 1G the forwarded clock sits 2 ns late, centred in the data window.
// - At 10 and 100M the clock register inputs toggle at the nibble rate.
// - The quadrature reference clocks no register; it only selects the forwarded-clock output mux.
// - Receive logic runs on the transmit reference, paced by sampled edges of the PHY receive clock.
// - A receive qualifier strobe is derived on the reference from sampled receive clock edges and handed out.
// - References may be shared; each instance takes its own PHY receive clock.
module rgi_phy_if
   import rgi_pkg::*;
#(
   parameter int DIV_100M = RGI_DIV_100M,
   parameter int DIV_10M = RGI_DIV_10M
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic tx_reference_clock_quadrature_in,
   input wire rgi_speed_t speed_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_valid_in,
   input wire logic tx_error_in,
   output logic tx_ready_out,
   output logic tx_enable_out,
   output logic [3:0] rgmii_txd_out,
   output logic rgmii_tx_ctl_out,
   output logic rgmii_txc_out,
   input wire logic rgmii_rxc_in,
   input wire logic [3:0] rgmii_rxd_in,
   input wire logic rgmii_rx_ctl_in,
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   output logic rx_error_out,
   output logic rx_enable_out
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   if (DIV_100M < 2 || DIV_100M % 2 != 0 || DIV_10M < 2 || DIV_10M % 2 != 0 ||
       DIV_10M >= (1 << RGI_CNT_W) || DIV_100M >= (1 << RGI_CNT_W)) begin : g_bad_div
      $error("Strobe divisors must be even, at least 2 and fit the counter");
   end
   if (RGI_TXC_SKEW_QUARTERS != 1) begin : g_bad_skew
      $error("Gigabit clock skew must equal a quarter reference period");
   end

   function automatic logic [RGI_CNT_W-1:0] div_of(input rgi_speed_t spd);
      logic [RGI_CNT_W-1:0] d;
      d = RGI_CNT_W'(RGI_DIV_1G);
      if (spd == RGI_SPD_100M) begin
         d = RGI_CNT_W'(DIV_100M);
      end else if (spd == RGI_SPD_10M) begin
         d = RGI_CNT_W'(DIV_10M);
      end
      return d;
   endfunction : div_of

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Transmit strobe generator

   rgi_speed_t spd_q;
   logic [RGI_CNT_W-1:0] cnt;
   logic [RGI_CNT_W-1:0] cnt_d;
   logic [RGI_CNT_W-1:0] next_cnt;
   logic spd_changed;

   assign spd_changed = (speed_in != spd_q);

   always_comb begin
      next_cnt = cnt + RGI_CNT_W'(1);
      if (spd_changed || cnt >= div_of(speed_in) - RGI_CNT_W'(1)) begin
         next_cnt = RGI_CNT_RST;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt <= RGI_CNT_RST;
         cnt_d <= RGI_CNT_RST;
         spd_q <= RGI_SPD_10M;
      end else begin
         cnt <= next_cnt;
         cnt_d <= cnt;
         spd_q <= speed_in;
      end
   end

   // qualifier handed to the MAC and throttling the user
   assign tx_enable_out = reset_n_in && (cnt == RGI_CNT_RST);
   assign tx_ready_out = tx_enable_out;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Transmit byte capture and two-edge register loading

   rgi_word_t tx_word;
   rgi_ddr_t tx_ddr;
   rgi_ddr_t next_tx_ddr;

   // new word taken on each strobe cycle, whether valid is set or not
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_word <= RGI_WORD_RST;
      end else if (tx_enable_out) begin
         tx_word <= '{tx_data_in, tx_valid_in, tx_error_in};
      end
   end

   always_comb begin
      logic [RGI_CNT_W-1:0] half;
      logic [RGI_CNT_W-1:0] pos;
      logic [3:0] nib;
      half = div_of(spd_q) >> 1;
      pos = cnt_d;
      nib = tx_word.data[3:0];
      if (spd_q == RGI_SPD_1G) begin
         // low nibble rising, high nibble falling
         next_tx_ddr.d_rise = tx_word.data[3:0];
         next_tx_ddr.d_fall = tx_word.data[7:4];
         // full-rate clock, phase set by quadrature mux
         next_tx_ddr.clk_rise = 1'b1;
         next_tx_ddr.clk_fall = 1'b0;
      end else begin
         if (cnt_d >= half) begin
            pos = cnt_d - half;
            nib = tx_word.data[7:4];
         end
         next_tx_ddr.d_rise = nib;
         next_tx_ddr.d_fall = nib;
         // clock high for the first half of each nibble period
         next_tx_ddr.clk_rise = ({pos, 1'b0} < {1'b0, half});
         next_tx_ddr.clk_fall = ({pos, 1'b1} < {1'b0, half});
      end
      // control: valid, then valid xor error
      next_tx_ddr.ctl_rise = tx_word.valid;
      next_tx_ddr.ctl_fall = tx_word.valid ^ tx_word.error;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_ddr <= RGI_DDR_RST;
      end else begin
         tx_ddr <= next_tx_ddr;
      end
   end

   // pad mux: rising-half value while the reference is high
   assign rgmii_txd_out = clk_in ? tx_ddr.d_rise : tx_ddr.d_fall;
   assign rgmii_tx_ctl_out = clk_in ? tx_ddr.ctl_rise : tx_ddr.ctl_fall;

   // Falling-half clock value, held from mid-cycle so the quadrature low phase that
   // spans the next reference edge still shows it and the forwarded clock never glitches
   logic txc_fall_q;

   always_ff @(negedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         txc_fall_q <= 1'b0;
      end else begin
         txc_fall_q <= tx_ddr.clk_fall;
      end
   end

   // rising half from the two-edge register, falling half from the mid-cycle hold, selected by the quadrature reference
   assign rgmii_txc_out = tx_reference_clock_quadrature_in ? tx_ddr.clk_rise : txc_fall_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Receive pin synchronisers

   logic rxc_s1, rxc_s2, rxc_s3;
   logic [3:0] rxd_s1, rxd_s2;
   logic rxctl_s1, rxctl_s2;
   logic rx_rise, rx_fall;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rxc_s1 <= 1'b0;
         rxc_s2 <= 1'b0;
         rxc_s3 <= 1'b0;
         rxd_s1 <= RGI_NIBBLE_RST;
         rxd_s2 <= RGI_NIBBLE_RST;
         rxctl_s1 <= 1'b0;
         rxctl_s2 <= 1'b0;
      end else begin
         rxc_s1 <= rgmii_rxc_in;
         rxc_s2 <= rxc_s1;
         rxc_s3 <= rxc_s2;
         rxd_s1 <= rgmii_rxd_in;
         rxd_s2 <= rxd_s1;
         rxctl_s1 <= rgmii_rx_ctl_in;
         rxctl_s2 <= rxctl_s1;
      end
   end

   // receive pacing comes from this instance's own PHY clock edges
   assign rx_rise = rxc_s2 && !rxc_s3;
   assign rx_fall = !rxc_s2 && rxc_s3;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Receive byte assembly and qualifier

   logic [3:0] rx_low;
   logic rx_dv;
   logic rx_fall_ctl;
   logic rx_phase;
   rgi_word_t rx_word;
   logic rx_strobe;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_low <= RGI_NIBBLE_RST;
         rx_dv <= 1'b0;
         rx_fall_ctl <= 1'b0;
         rx_phase <= 1'b0;
         rx_word <= RGI_WORD_RST;
         rx_strobe <= 1'b0;
      end else begin
         rx_strobe <= 1'b0;
         if (speed_in == RGI_SPD_1G) begin
            rx_phase <= 1'b0;
            // low nibble and valid on rising edge
            if (rx_rise) begin
               rx_low <= rxd_s2;
               rx_dv <= rxctl_s2;
            end
            // byte and strobe on the falling edge
            if (rx_fall) begin
               rx_word <= '{{rxd_s2, rx_low}, rx_dv, rx_dv ^ rxctl_s2};
               rx_strobe <= 1'b1;
            end
         end else begin
            if (rx_fall) begin
               rx_fall_ctl <= rxctl_s2;
            end
            if (rx_rise && !rx_phase) begin
               rx_low <= rxd_s2;
               rx_dv <= rxctl_s2;
               rx_phase <= rxctl_s2;
            end else if (rx_rise) begin
               // one byte per two nibble periods
               rx_word <= '{{rxd_s2, rx_low}, rx_dv && rxctl_s2, rx_dv ^ rx_fall_ctl};
               rx_strobe <= 1'b1;
               rx_phase <= 1'b0;
            end
         end
      end
   end

   assign rx_data_out = rx_word.data;
   assign rx_valid_out = rx_word.valid;
   assign rx_error_out = rx_word.error;
   assign rx_enable_out = rx_strobe;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions

   logic [RGI_CNT_W-1:0] gap;
   logic spd_settled;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gap <= RGI_CNT_RST;
         spd_settled <= 1'b0;
      end else begin
         gap <= tx_enable_out ? RGI_CNT_RST : gap + RGI_CNT_W'(1);
         spd_settled <= !spd_changed && (tx_enable_out ? 1'b1 : spd_settled);
      end
   end

   a_strobe_spacing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (tx_enable_out && spd_settled && !spd_changed && speed_in != RGI_SPD_1G)
         |-> (gap == div_of(speed_in) - RGI_CNT_W'(1)))
      else $error("Transmit strobe spacing does not match the link speed");

   a_strobe_gig: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (speed_in == RGI_SPD_1G && spd_q == RGI_SPD_1G) |-> tx_enable_out)
      else $error("Transmit strobe missing at gigabit");

   a_word_capture: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      tx_enable_out |=> (tx_word.data == $past(tx_data_in) && tx_word.valid == $past(tx_valid_in) &&
         tx_word.error == $past(tx_error_in)))
      else $error("Transmit word not taken on strobe");

   a_gig_nibbles: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (tx_enable_out && speed_in == RGI_SPD_1G && spd_q == RGI_SPD_1G) ##1 (spd_q == RGI_SPD_1G)
         |=> (tx_ddr.d_rise == $past(tx_data_in[3:0], 2) && tx_ddr.d_fall == $past(tx_data_in[7:4], 2)))
      else $error("Gigabit nibble order wrong");

   a_ctl_error: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (tx_enable_out && tx_valid_in && tx_error_in) |-> ##2 (tx_ddr.ctl_rise && !tx_ddr.ctl_fall))
      else $error("Control falling half must flag the error");

   a_gig_clock: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (spd_q == RGI_SPD_1G) |=> (tx_ddr.clk_rise && !tx_ddr.clk_fall))
      else $error("Gigabit forwarded clock pattern wrong");

   a_clock_100m: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      ($rose(tx_ddr.clk_rise) && spd_settled && speed_in == RGI_SPD_100M && DIV_100M == 10)
         ##1 (speed_in == RGI_SPD_100M) [*5] |-> $rose(tx_ddr.clk_rise))
      else $error("Forwarded clock period wrong at 100M");

   a_rx_after_edge: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      rx_enable_out |-> $past(rx_rise || rx_fall))
      else $error("Receive strobe without a receive clock edge");

   a_rx_single: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      rx_enable_out |=> !rx_enable_out)
      else $error("Receive strobe longer than one cycle");

endmodule : rgi_phy_if

// File: test/rgi_phy_model.sv
// Behavioural PHY receive side driving the RGMII receive clock, data and control
`timescale 1ns/100ps
module rgi_phy_model (
   output logic rxc_out,
   output logic [3:0] rxd_out,
   output logic rx_ctl_out
);
   initial begin
      rxc_out = 1'b0;
      rxd_out = 4'h0;
      rx_ctl_out = 1'b0;
   end
   task automatic send(input bit gig, input logic [7:0] b, input bit err);
      // Keep pin changes off the sampling clock's edges
      #3;
      rxd_out = b[3:0];
      rx_ctl_out = 1'b1;
      #16 rxc_out = 1'b1;
      #16;
      if (gig) begin
         rxd_out = b[7:4];
         rx_ctl_out = ~err;
      end
      #16 rxc_out = 1'b0;
      #16;
      if (!gig) begin
         rxd_out = b[7:4];
         #16 rxc_out = 1'b1;
         #32 rxc_out = 1'b0;
         #16;
      end
      // Clock stands still; released data shows the inverse
      rxd_out = ~rxd_out;
      rx_ctl_out = 1'b0;
   endtask : send
endmodule : rgi_phy_model

// File: test/tb_top.sv
// Self-checking bench for the RGMII tri-speed interface
`timescale 1ns/100ps
module tb_top;
   import rgi_pkg::*;
   logic clk = 1'b0;
   logic quad = 1'b0;
   logic reset_n = 1'b0;
   rgi_speed_t speed = RGI_SPD_1G;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic tx_error = 1'b0;
   logic tx_ready, tx_enable, txc, tx_ctl, rxc, rx_ctl, rx_valid, rx_error, rx_enable;
   logic [3:0] txd, rxd;
   logic [7:0] rx_data;
   int num_errors = 0;
   int total_checks = 0;
   int txc_rises = 0;

   initial forever #4 clk = ~clk;
   initial begin
      #2;
      forever #4 quad = ~quad;
   end
   always @(posedge txc) txc_rises++;

   rgi_phy_if DUT (
      .clk_in(clk), .reset_n_in(reset_n), .tx_reference_clock_quadrature_in(quad),
      .speed_in(speed), .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_error_in(tx_error),
      .tx_ready_out(tx_ready), .tx_enable_out(tx_enable), .rgmii_txd_out(txd),
      .rgmii_tx_ctl_out(tx_ctl), .rgmii_txc_out(txc), .rgmii_rxc_in(rxc),
      .rgmii_rxd_in(rxd), .rgmii_rx_ctl_in(rx_ctl), .rx_data_out(rx_data),
      .rx_valid_out(rx_valid), .rx_error_out(rx_error), .rx_enable_out(rx_enable)
   );
   rgi_phy_model PHY (.rxc_out(rxc), .rxd_out(rxd), .rx_ctl_out(rx_ctl));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////
   // Strobe rate and forwarded clock frequency over 400 cycles
   task automatic strobe_rate(input rgi_speed_t s, input int div);
      int cnt;
      int exp;
      cnt = 0;
      exp = (div == 1) ? 400 : 800 / div;
      @(posedge clk) speed <= s;
      repeat (3) @(posedge clk);
      #1 txc_rises = 0;
      repeat (400) begin
         @(posedge clk);
         #1;
         cnt += (tx_enable === 1'b1);
         check(tx_ready, tx_enable, "ready");
      end
      check(cnt, 400 / div, "strobes");
      check(txc_rises >= exp - 1 && txc_rises <= exp + 1, 1'b1, "txc rate");
   endtask : strobe_rate

   // One byte offered on the strobe, then its nibbles watched at the pads
   task automatic tx_byte(input int div, input logic [7:0] b, input logic e);
      @(posedge clk);
      tx_data <= b;
      tx_valid <= 1'b1;
      tx_error <= e;
      #1;
      for (int i = 0; i < 200 && tx_enable !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      tx_valid <= 1'b0;
      // Pads show the byte in the cycle after the one that follows the capture edge
      @(posedge clk);
      #1;
      if (div == 1) check(txc, 1'b0, "txc lag");
      #2;
      if (div == 1) check(txc, 1'b1, "txc lag");
      check(txd, b[3:0], "low nibble");
      check(tx_ctl, 1'b1, "ctl rise");
      if (div == 1) begin
         #4;
         check(tx_ctl, !e, "ctl fall");
      end else begin
         repeat (div / 2) @(posedge clk);
         #3;
      end
      check(txd, b[7:4], "high nibble");
   endtask : tx_byte

   // Byte from the PHY must come out with one receive strobe
   task automatic rx_byte(input rgi_speed_t s, input logic [7:0] b, input logic e);
      @(posedge clk) speed <= s;
      fork
         PHY.send(s == RGI_SPD_1G, b, e);
         begin
            for (int i = 0; i < 40 && rx_enable !== 1'b1; i++) begin
               @(posedge clk);
               #1;
            end
            check(rx_enable, 1'b1, "rx strobe");
            check(rx_data, b, "rx data");
            check(rx_valid, 1'b1, "rx valid");
            check(rx_error, e, "rx error");
            @(posedge clk);
            #1;
            check(rx_enable, 1'b0, "rx pulse");
         end
      join
   endtask : rx_byte

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      strobe_rate(RGI_SPD_1G, 1);
      tx_byte(1, 8'ha5, 1'b0);
      tx_byte(1, 8'h3c, 1'b1);
      strobe_rate(RGI_SPD_100M, RGI_DIV_100M);
      tx_byte(RGI_DIV_100M, 8'h96, 1'b0);
      strobe_rate(RGI_SPD_10M, RGI_DIV_10M);
      tx_byte(RGI_DIV_10M, 8'h7e, 1'b0);
      rx_byte(RGI_SPD_1G, 8'hc3, 1'b0);
      rx_byte(RGI_SPD_1G, 8'h5a, 1'b1);
      rx_byte(RGI_SPD_100M, 8'h69, 1'b0);
      rx_byte(RGI_SPD_10M, 8'ha1, 1'b0);
      complete_run();
   end

   // Tests need about 1500 cycles; allow over four times that
   initial begin
      #50000;
      num_errors++;
      complete_run();
   end
endmodule : tb_top
